// [rtl/ucb_pkg.sv]
package ucb_pkg;

    // Register offsets
    localparam logic [2:0] A_CTRL1 = 3'h0;
    localparam logic [2:0] A_CTRL2 = 3'h1;
    localparam logic [2:0] A_DATA  = 3'h2;
    localparam logic [2:0] A_BAUD  = 3'h3;
    localparam logic [2:0] A_STAT  = 3'h4;

    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Status bit positions
    localparam int S_TXEMPTY = 0;
    localparam int S_TXIDLE  = 1;
    localparam int S_RXAVAIL = 2;
    localparam int S_RXIDLE  = 3;
    localparam int S_OVERRUN = 4;
    localparam int S_FRAME   = 5;
    localparam int S_WAKE    = 6;

    // Timing counts
    localparam logic [1:0] LOW_PRE  = 2'h3;
    localparam logic [3:0] PH_LAST  = 4'hF;
    localparam logic [3:0] PH_MID   = 4'h7;
    localparam int         BRK_BITS = 13;

    typedef struct packed {
        logic glb;
        logic wordLenSel;
        logic parEn;
        logic parOdd;
        logic twoStop;
        logic sendBreakCtl;
        logic rxNinthBit;
        logic txNinthBit;
    } ucb_ctrl1_t;

    typedef struct packed {
        logic txEnableCtl;
        logic rxEnableCtl;
        logic baudSpeedSel;
        logic addrDetectEn;
        logic wakeEn;
        logic rxIntEn;
        logic txIdleIntEn;
        logic txEmptyIntEn;
    } ucb_ctrl2_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ucb_req_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_STOP  = 3'b011,
        TX_BREAK = 3'b100
    } ucb_tx_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } ucb_rx_t;

endpackage

// [rtl/ucb_uart.sv]
// Function
// - Break waits for buffer, holds low 13+ bits
// - Ninth received bit stored in 9-bit mode
// - Ninth transmitted bit from control field
// - Transmit disable aborts, clears, floats TX
// - TX driven only with both enables set
// - Receive disable aborts, clears receive buffer
// - RX received only with both enables set; wake detect watches it always
// - Baud is core clock over 64(N+1) or 16(N+1)
// - Free-running 8-bit divider, any N
// - Address bit is bit 8 or 9
// - Non-address words discarded without interrupt
// - Every addressed word raises receive interrupt
// - RX fall while clock stopped requests wake
// - No wake request when running or disabled
// - Receive enable gates overrun and avail
// - Idle enable gates transmitter idle flag
// - Empty enable gates transmit empty flag
// - One data register for both directions
// - Global disable empties buffers, resets flags except wake
// - Word length selects eight or nine bits
module ucb_uart #(
    parameter int unsigned BRK_BITS = ucb_pkg::BRK_BITS
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Register port
    input  wire ucb_pkg::ucb_req_t req,
    output logic [7:0]             rdata,
    // Serial pins
    input  wire logic              rxPin,
    output logic                   txOut,
    output logic                   txOe,
    // Clock control and interrupt
    input  wire logic              coreClkStopped,
    output logic                   intReq
);

    if (BRK_BITS < 13 || BRK_BITS > 255) begin : g_chk
        $error("BRK_BITS out of range");
    end

    ////////////////////////////////////////////////////////////
    // Registers
    ucb_pkg::ucb_ctrl1_t c1Q;
    ucb_pkg::ucb_ctrl2_t c2Q;
    logic [7:0]          divQ;
    logic                glb;
    logic                txRun;
    logic                rxRun;
    logic                dataWr;
    logic                dataRd;

    assign glb    = c1Q.glb;
    assign txRun  = glb && c2Q.txEnableCtl;
    assign rxRun  = glb && c2Q.rxEnableCtl;
    assign dataWr = req.we && req.addr == ucb_pkg::A_DATA;
    assign dataRd = req.re && req.addr == ucb_pkg::A_DATA;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            c1Q  <= ucb_pkg::RST_CTRL;
            c2Q  <= ucb_pkg::RST_CTRL;
            divQ <= ucb_pkg::RST_ZERO;
        end else begin
            if (req.we && req.addr == ucb_pkg::A_CTRL1) begin
                c1Q <= req.wdata;
            end
            if (req.we && req.addr == ucb_pkg::A_CTRL2) begin
                c2Q <= req.wdata;
            end
            if (req.we && req.addr == ucb_pkg::A_BAUD) begin
                divQ <= req.wdata;
            end
            if (!glb || (req.we && req.addr == ucb_pkg::A_CTRL1 && !req.wdata[7])) begin
                c2Q.txEnableCtl  <= 1'b0;
                c2Q.rxEnableCtl  <= 1'b0;
                c1Q.sendBreakCtl <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Baud generator, 16 ticks per bit
    logic [7:0] bCntQ;
    logic [1:0] preQ;
    logic       tick;

    assign tick = glb && bCntQ == 8'h00 && (c2Q.baudSpeedSel || preQ == ucb_pkg::LOW_PRE);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bCntQ <= 8'h00;
            preQ  <= 2'h0;
        end else if (!glb) begin
            bCntQ <= 8'h00;
            preQ  <= 2'h0;
        end else if (bCntQ == 8'h00) begin
            bCntQ <= divQ;
            preQ  <= preQ + 2'h1;
        end else begin
            bCntQ <= bCntQ - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////
    // Transmitter
    ucb_pkg::ucb_tx_t txStQ;
    logic [7:0]       txBufQ;
    logic             txFullQ;
    logic             txRunQ;
    logic [8:0]       txShQ;
    logic [3:0]       txPhQ;
    logic [7:0]       txBitQ;
    logic             txLineQ;
    logic             txBitDone;
    logic             txLoad;
    logic             txIdle;
    logic             inBrk;

    assign txBitDone = tick && txPhQ == ucb_pkg::PH_LAST;
    assign txLoad    = txRun && txStQ == ucb_pkg::TX_IDLE && txFullQ && tick;
    assign txIdle    = !txFullQ && txStQ == ucb_pkg::TX_IDLE;
    assign inBrk     = txStQ == ucb_pkg::TX_BREAK;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txRunQ  <= 1'b0;
            txFullQ <= 1'b0;
            txBufQ  <= 8'h00;
        end else begin
            txRunQ <= txRun;
            if (!glb || (txRunQ && !txRun)) begin
                txFullQ <= 1'b0;
            end else begin
                if (txLoad) begin
                    txFullQ <= 1'b0;
                end
                if (dataWr) begin
                    txFullQ <= 1'b1;
                    txBufQ  <= req.wdata;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txStQ   <= ucb_pkg::TX_IDLE;
            txShQ   <= 9'h000;
            txPhQ   <= 4'h0;
            txBitQ  <= 8'h00;
            txLineQ <= 1'b1;
        end else if (!txRun) begin
            txStQ   <= ucb_pkg::TX_IDLE;
            txLineQ <= 1'b1;
        end else begin
            if (tick) begin
                txPhQ <= txPhQ + 4'h1;
            end
            unique case (txStQ)
                ucb_pkg::TX_IDLE: begin
                    txPhQ  <= 4'h0;
                    txBitQ <= 8'h00;
                    // Frames start on a tick so the start bit is a full bit long
                    if (txFullQ && tick) begin
                        txShQ   <= {c1Q.wordLenSel ? c1Q.txNinthBit : 1'b1, txBufQ};
                        txStQ   <= ucb_pkg::TX_START;
                        txLineQ <= 1'b0;
                    end else if (!txFullQ && tick && c1Q.sendBreakCtl) begin
                        txStQ   <= ucb_pkg::TX_BREAK;
                        txLineQ <= 1'b0;
                    end
                end
                ucb_pkg::TX_START: begin
                    if (txBitDone) begin
                        txStQ   <= ucb_pkg::TX_DATA;
                        txLineQ <= txShQ[0];
                        txShQ   <= {1'b1, txShQ[8:1]};
                    end
                end
                ucb_pkg::TX_DATA: begin
                    if (txBitDone) begin
                        if (txBitQ == (c1Q.wordLenSel ? 8'h08 : 8'h07)) begin
                            txStQ   <= ucb_pkg::TX_STOP;
                            txLineQ <= 1'b1;
                            txBitQ  <= 8'h00;
                        end else begin
                            txLineQ <= txShQ[0];
                            txShQ   <= {1'b1, txShQ[8:1]};
                            txBitQ  <= txBitQ + 8'h01;
                        end
                    end
                end
                ucb_pkg::TX_STOP: begin
                    if (txBitDone) begin
                        if (c1Q.twoStop && txBitQ == 8'h00) begin
                            txBitQ <= 8'h01;
                        end else begin
                            txStQ <= ucb_pkg::TX_IDLE;
                        end
                    end
                end
                ucb_pkg::TX_BREAK: begin
                    txLineQ <= 1'b0;
                    if (txBitDone && txBitQ != 8'hFF) begin
                        txBitQ <= txBitQ + 8'h01;
                    end
                    if (!c1Q.sendBreakCtl && txBitQ >= 8'(BRK_BITS)) begin
                        txStQ   <= ucb_pkg::TX_IDLE;
                        txLineQ <= 1'b1;
                    end
                end
                default: begin
                    txStQ <= ucb_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txOut <= 1'b1;
            txOe  <= 1'b0;
        end else begin
            txOut <= txLineQ;
            txOe  <= txRun;
        end
    end

    ////////////////////////////////////////////////////////////
    // Receiver
    ucb_pkg::ucb_rx_t rxStQ;
    logic             rxS1Q;
    logic             rxS2Q;
    logic             rxPrevQ;
    logic             csS1Q;
    logic             csS2Q;
    logic [3:0]       rxPhQ;
    logic [3:0]       rxCntQ;
    logic [8:0]       rxShQ;
    logic [7:0]       rxDataQ;
    logic             rx9Q;
    logic             availQ;
    logic             ovrQ;
    logic             ferrQ;
    logic             wakeQ;
    logic             rxFall;
    logic             wordDone;
    logic             addrBit;
    logic             keep;
    logic [7:0]       rxByte;

    assign rxFall   = rxPrevQ && !rxS2Q;
    assign wordDone = rxStQ == ucb_pkg::RX_STOP && tick && rxPhQ == ucb_pkg::PH_LAST;
    assign rxByte   = c1Q.wordLenSel ? rxShQ[7:0] : rxShQ[8:1];
    assign addrBit  = c1Q.wordLenSel ? rxShQ[8] : rxByte[7];
    assign keep     = !(c2Q.addrDetectEn && !addrBit);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxS1Q   <= 1'b1;
            rxS2Q   <= 1'b1;
            rxPrevQ <= 1'b1;
            csS1Q   <= 1'b0;
            csS2Q   <= 1'b0;
        end else begin
            rxS1Q   <= rxPin;
            rxS2Q   <= rxS1Q;
            rxPrevQ <= rxS2Q;
            csS1Q   <= coreClkStopped;
            csS2Q   <= csS1Q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxStQ  <= ucb_pkg::RX_IDLE;
            rxPhQ  <= 4'h0;
            rxCntQ <= 4'h0;
            rxShQ  <= 9'h000;
        end else if (!rxRun) begin
            rxStQ <= ucb_pkg::RX_IDLE;
        end else begin
            if (tick) begin
                rxPhQ <= rxPhQ + 4'h1;
            end
            unique case (rxStQ)
                ucb_pkg::RX_IDLE: begin
                    rxPhQ  <= 4'h0;
                    rxCntQ <= 4'h0;
                    if (rxFall) begin
                        rxStQ <= ucb_pkg::RX_START;
                    end
                end
                ucb_pkg::RX_START: begin
                    if (tick && rxPhQ == ucb_pkg::PH_MID) begin
                        rxPhQ <= 4'h0;
                        rxStQ <= rxS2Q ? ucb_pkg::RX_IDLE : ucb_pkg::RX_DATA;
                    end
                end
                ucb_pkg::RX_DATA: begin
                    if (tick && rxPhQ == ucb_pkg::PH_LAST) begin
                        rxShQ  <= {rxS2Q, rxShQ[8:1]};
                        rxCntQ <= rxCntQ + 4'h1;
                        if (rxCntQ == (c1Q.wordLenSel ? 4'h8 : 4'h7)) begin
                            rxStQ <= ucb_pkg::RX_STOP;
                        end
                    end
                end
                ucb_pkg::RX_STOP: begin
                    if (wordDone) begin
                        rxStQ <= ucb_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxDataQ <= 8'h00;
            rx9Q    <= 1'b0;
            availQ  <= 1'b0;
            ovrQ    <= 1'b0;
            ferrQ   <= 1'b0;
        end else if (!rxRun) begin
            availQ <= 1'b0;
            ovrQ   <= 1'b0;
            ferrQ  <= 1'b0;
        end else begin
            if (dataRd) begin
                availQ <= 1'b0;
                ovrQ   <= 1'b0;
                ferrQ  <= 1'b0;
            end
            if (wordDone && keep) begin
                if (availQ && !dataRd) begin
                    ovrQ <= 1'b1;
                end else begin
                    rxDataQ <= rxByte;
                    availQ  <= 1'b1;
                    ferrQ   <= !rxS2Q;
                    if (c1Q.wordLenSel) begin
                        rx9Q <= rxShQ[8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wakeQ <= 1'b0;
        end else if (rxFall && csS2Q && c2Q.wakeEn) begin
            wakeQ <= 1'b1;
        end else if (req.we && req.addr == ucb_pkg::A_STAT && req.wdata[ucb_pkg::S_WAKE]) begin
            wakeQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////
    // Interrupt and read data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            intReq <= 1'b0;
        end else begin
            intReq <= (c2Q.rxIntEn && (availQ || ovrQ || wakeQ))
                   || (c2Q.txIdleIntEn && txIdle)
                   || (c2Q.txEmptyIntEn && !txFullQ);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (!req.re) begin
            rdata <= 8'h00;
        end else begin
            unique case (req.addr)
                ucb_pkg::A_CTRL1: rdata <= {c1Q[7:2], rx9Q, 1'b0};
                ucb_pkg::A_CTRL2: rdata <= c2Q;
                ucb_pkg::A_DATA:  rdata <= rxDataQ;
                ucb_pkg::A_BAUD:  rdata <= divQ;
                ucb_pkg::A_STAT:  rdata <= {1'b0, wakeQ, ferrQ, ovrQ, rxStQ == ucb_pkg::RX_IDLE,
                                            availQ, txIdle, !txFullQ};
                default:          rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Checks
    logic [10:0] gapQ;
    logic        gapOkQ;
    logic [10:0] gapExp;

    assign gapExp = c2Q.baudSpeedSel ? 11'(divQ) + 11'h001 : (11'(divQ) + 11'h001) << 2;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gapQ   <= 11'h000;
            gapOkQ <= 1'b0;
        end else begin
            gapQ <= tick ? 11'h001 : gapQ + 11'h001;
            if (tick) begin
                gapOkQ <= 1'b1;
            end
            if (!glb || (req.we && (req.addr == ucb_pkg::A_BAUD || req.addr == ucb_pkg::A_CTRL2))) begin
                gapOkQ <= 1'b0;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_baud;
        tick && gapOkQ |-> gapQ == gapExp;
    endproperty
    a_baud: assert property (p_baud) else $error("baud tick spacing wrong");

    property p_brk_low;
        inBrk && $past(inBrk) |-> !txOut;
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break not low");

    property p_brk_len;
        $fell(inBrk) && txRun |-> $past(txBitQ) >= 8'(BRK_BITS);
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break too short");

    property p_oe;
        ##1 txOe == $past(glb && c2Q.txEnableCtl);
    endproperty
    a_oe: assert property (p_oe) else $error("TX drive without enables");

    property p_discard;
        wordDone && rxRun && c2Q.addrDetectEn && !addrBit && !availQ |=> !availQ;
    endproperty
    a_discard: assert property (p_discard) else $error("non-address word kept");

    property p_rxint;
        availQ && c2Q.rxIntEn && $stable(c2Q) |=> intReq;
    endproperty
    a_rxint: assert property (p_rxint) else $error("receive interrupt missing");

    property p_idleint;
        txIdle && c2Q.txIdleIntEn && $stable(c2Q) |=> intReq;
    endproperty
    a_idleint: assert property (p_idleint) else $error("idle interrupt missing");

    property p_quiet;
        !c2Q.rxIntEn && !c2Q.txIdleIntEn && !c2Q.txEmptyIntEn && $stable(c2Q) |=> !intReq;
    endproperty
    a_quiet: assert property (p_quiet) else $error("interrupt with no source");

    property p_disable;
        !glb |=> !availQ && !txFullQ && !c2Q.txEnableCtl;
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not reset");

    property p_nowake;
        !csS2Q || !c2Q.wakeEn |=> !$rose(wakeQ);
    endproperty
    a_nowake: assert property (p_nowake) else $error("spurious wake");

    property p_ninth;
        wordDone && rxRun && keep && c1Q.wordLenSel && !availQ |=> rx9Q == $past(rxShQ[8]);
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit lost");

    c_break: cover property (inBrk [*8]);
    c_word:  cover property (wordDone && keep);
    c_wake:  cover property ($rose(wakeQ));
    c_ovr:   cover property ($rose(ovrQ));

endmodule

// [tb/ucb_remote.sv]
module ucb_remote (
    // Clock
    input  wire logic        clk_sys,
    // Serial lines
    input  wire logic        txLine,
    output logic             rxLine,
    // Frame setup and capture
    input  wire logic [15:0] bitCycles,
    input  wire logic        nineBits,
    output logic [8:0]       capWord,
    output int               capLow,
    output int               capCount
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [8:0] w;
    time        fallT;

    initial begin
        rxLine = 1'b1;
        capWord = '0;
        capLow = 0;
        capCount = 0;
        fallT = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Length of the most recent low run on the line
    always @(negedge txLine) fallT = $time;
    always @(posedge txLine) capLow = int'(($time - fallT) / 50);

    ////////////////////////////////////////////////////////////////////////
    // Frame capture, sampled mid bit, LSB first
    always begin
        @(negedge txLine);
        repeat (bitCycles / 2) @(posedge clk_sys);
        w = '0;
        for (int i = 0; i < (nineBits ? 9 : 8); i++) begin
            repeat (bitCycles) @(posedge clk_sys);
            w[i] = txLine;
        end
        repeat (bitCycles) @(posedge clk_sys);
        capWord = w;
        capCount++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame send: start, data LSB first, stop bits
    task automatic sendWord(input logic [8:0] dw);
        logic [10:0] fr;
        fr = nineBits ? {1'b1, dw, 1'b0} : {2'b11, dw[7:0], 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxLine <= fr[i];
            repeat (bitCycles) @(posedge clk_sys);
        end
    endtask
endmodule

// [tb/testbench.sv]
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } ucb_row_t;

    logic              clk_sys;
    logic              rst;
    ucb_pkg::ucb_req_t req;
    logic [7:0]        rdata;
    logic              rxPin;
    logic              txOut;
    logic              txOe;
    logic              txWire;
    logic              coreClkStopped;
    logic              intReq;
    logic [15:0]       bitCycles;
    logic              nine;
    logic [8:0]        capWord;
    int                capLow;
    int                capCount;
    int                n_mismatch;
    int                checks_done;
    logic [7:0]        d;
    logic              lowOk;
    ucb_row_t          rows [13];

    // Released TX line is pulled up
    assign txWire = txOe ? txOut : 1'b1;

    ucb_uart i_dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .rxPin(rxPin),
                    .txOut(txOut), .txOe(txOe), .coreClkStopped(coreClkStopped), .intReq(intReq));

    ucb_remote i_remote (.clk_sys(clk_sys), .txLine(txWire), .rxLine(rxPin), .bitCycles(bitCycles),
                         .nineBits(nine), .capWord(capWord), .capLow(capLow), .capCount(capCount));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and closing tasks
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys);
        req.we <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a);
        req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        req.re <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic waitFrame();
        int c0;
        c0 = capCount;
        for (int i = 0; i < 3000 && capCount == c0; i++) @(posedge clk_sys);
        if (capCount == c0) n_mismatch++;
    endtask

    task automatic rxw(input logic [8:0] w);
        i_remote.sendWord(w);
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic results();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        n_mismatch++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        req = '0;
        coreClkStopped = 1'b0;
        bitCycles = 16'h0010;
        nine = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        rows = '{'{1'b0, 3'h0, 8'h00, 8'h00}, '{1'b0, 3'h1, 8'h00, 8'h00}, '{1'b0, 3'h3, 8'h00, 8'h00},
                 '{1'b0, 3'h4, 8'h00, 8'h0B}, '{1'b1, 3'h3, 8'hFF, 8'h00}, '{1'b0, 3'h3, 8'h00, 8'hFF},
                 '{1'b1, 3'h0, 8'h81, 8'h00}, '{1'b0, 3'h0, 8'h00, 8'h80}, '{1'b1, 3'h5, 8'hFF, 8'h00},
                 '{1'b0, 3'h5, 8'h00, 8'h00}, '{1'b1, 3'h1, 8'hC0, 8'h00}, '{1'b0, 3'h1, 8'h00, 8'hC0},
                 '{1'b0, 3'h4, 8'h00, 8'h0B}};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].wdata);
            end else begin
                rd(rows[i].addr);
                `CHK(d, rows[i].exp)
            end
        end
        // Fast link, 8-bit then 9-bit transmit
        wr(ucb_pkg::A_BAUD, 8'h00);
        wr(ucb_pkg::A_CTRL2, 8'hE0);
        wr(ucb_pkg::A_DATA, 8'hA5);
        waitFrame();
        `CHK(capWord[7:0], 8'hA5)
        `CHK(capLow, 16)
        `CHK(txOe, 1'b1)
        wr(ucb_pkg::A_CTRL1, 8'hC1);
        nine = 1'b1;
        wr(ucb_pkg::A_DATA, 8'h3C);
        waitFrame();
        `CHK(capWord, 9'h13C)
        // 9-bit receive and overrun
        wr(ucb_pkg::A_CTRL2, 8'hE4);
        rxw(9'h15A);
        `CHK(intReq, 1'b1)
        rd(ucb_pkg::A_DATA);
        `CHK(d, 8'h5A)
        rd(ucb_pkg::A_CTRL1);
        `CHK(d[1], 1'b1)
        `CHK(intReq, 1'b0)
        rxw(9'h001);
        rxw(9'h002);
        rd(ucb_pkg::A_STAT);
        `CHK(d[4], 1'b1)
        rd(ucb_pkg::A_DATA);
        `CHK(d, 8'h01)
        // Address detect in both word lengths
        wr(ucb_pkg::A_CTRL2, 8'hF4);
        rxw(9'h05A);
        `CHK(intReq, 1'b0)
        rd(ucb_pkg::A_STAT);
        `CHK(d[2], 1'b0)
        rxw(9'h1A5);
        `CHK(intReq, 1'b1)
        rd(ucb_pkg::A_DATA);
        `CHK(d, 8'hA5)
        wr(ucb_pkg::A_CTRL1, 8'h80);
        nine = 1'b0;
        rxw(9'h07F);
        `CHK(intReq, 1'b0)
        rxw(9'h080);
        `CHK(intReq, 1'b1)
        rd(ucb_pkg::A_DATA);
        `CHK(d, 8'h80)
        // Wake on RX fall only with the core clock stopped
        wr(ucb_pkg::A_CTRL2, 8'h0C);
        rxw(9'h055);
        `CHK(intReq, 1'b0)
        coreClkStopped <= 1'b1;
        rxw(9'h055);
        `CHK(intReq, 1'b1)
        rd(ucb_pkg::A_STAT);
        `CHK(d[6], 1'b1)
        coreClkStopped <= 1'b0;
        wr(ucb_pkg::A_STAT, 8'h40);
        repeat (4) @(posedge clk_sys);
        `CHK(intReq, 1'b0)
        // Abort a frame by dropping the transmit enable
        wr(ucb_pkg::A_CTRL2, 8'hE0);
        wr(ucb_pkg::A_DATA, 8'h00);
        repeat (40) @(posedge clk_sys);
        wr(ucb_pkg::A_CTRL2, 8'h60);
        repeat (3) @(posedge clk_sys);
        `CHK(txOe, 1'b0)
        rd(ucb_pkg::A_STAT);
        `CHK(d[1:0], 2'b11)
        repeat (200) @(posedge clk_sys);
        // Break holds the line low for the full span
        wr(ucb_pkg::A_CTRL2, 8'hE0);
        wr(ucb_pkg::A_CTRL1, 8'h84);
        repeat (20) @(posedge clk_sys);
        lowOk = 1'b1;
        repeat (ucb_pkg::BRK_BITS * 16) begin
            @(posedge clk_sys);
            lowOk &= (txWire === 1'b0);
        end
        `CHK(lowOk, 1'b1)
        wr(ucb_pkg::A_CTRL1, 8'h80);
        repeat (64) @(posedge clk_sys);
        `CHK(txWire, 1'b1)
        // Slow link, divisor one
        wr(ucb_pkg::A_BAUD, 8'h01);
        wr(ucb_pkg::A_CTRL2, 8'hC0);
        bitCycles = 16'h0080;
        wr(ucb_pkg::A_DATA, 8'hA5);
        waitFrame();
        `CHK(capLow, 128)
        `CHK(capWord[7:0], 8'hA5)
        // Global disable clears enables and status, keeps other control bits
        wr(ucb_pkg::A_CTRL2, 8'hF4);
        wr(ucb_pkg::A_CTRL1, 8'h00);
        rd(ucb_pkg::A_CTRL2);
        `CHK(d, 8'h34)
        rd(ucb_pkg::A_STAT);
        `CHK(d, 8'h0B)
        `CHK(txOe, 1'b0)
        // Second reset in mid-run
        wr(ucb_pkg::A_CTRL1, 8'h80);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(ucb_pkg::A_CTRL1);
        `CHK(d, 8'h00)
        results();
    end
endmodule
